// >>> peripheral_irq_pkg.sv
// Constants, register map and carrier types for the peripheral interrupt enable block.
// Assumes one system clock, a synchronous active-low reset and a plain register port.

package peripheral_irq_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;

   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_ENABLE_ONE = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE_TWO = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_FLAG_ONE = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_FLAG_TWO = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_ACTIVE_ONE = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_ACTIVE_TWO = 4'h6;

   // ----------------------------------------------------------------
   // Field positions, bank two
   // ----------------------------------------------------------------
   localparam int BIT_OSC_FAIL = 7;
   localparam int BIT_COMPARATOR_B = 6;
   localparam int BIT_COMPARATOR_A = 5;
   localparam int BIT_NVM_WRITE_DONE = 4;
   localparam int BIT_SERIAL_BUS_COLLISION = 3;
   localparam int BIT_CAPTURE_UNIT_B = 0;

   // ----------------------------------------------------------------
   // Field positions, bank one and control
   // ----------------------------------------------------------------
   localparam int BIT_TIMER_TWO_MATCH = 1;
   localparam int BIT_TIMER_ONE_OVERFLOW = 0;
   localparam int BIT_PERIPH_GLOBAL_EN = 0;
   localparam int BIT_GLOBAL_EN = 1;

   // ----------------------------------------------------------------
   // Implemented masks and reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] MASK_BANK_TWO = 8'hF9;
   localparam logic [DATA_W-1:0] MASK_BANK_ONE = 8'h03;
   localparam logic [DATA_W-1:0] MASK_CONTROL = 8'h03;
   localparam logic [DATA_W-1:0] RESET_ENABLE = 8'h00;
   localparam logic [DATA_W-1:0] RESET_FLAG = 8'h00;
   localparam logic [DATA_W-1:0] RESET_CONTROL = 8'h00;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic osc_fail;
      logic comparator_b;
      logic comparator_a;
      logic nvm_write_done;
      logic serial_bus_collision;
      logic capture_unit_b;
      logic timer_one_overflow;
      logic timer_two_match;
   } periph_evt_t;

endpackage

// >>> irq_flag_bank.sv
// Sticky pending flags, set by events and cleared by writing ones.
// Assumes events and clear strobe come from logic on the same clock.

`timescale 1ns/10ps
`default_nettype none

module irq_flag_bank
   import peripheral_irq_pkg::*;
#(
   parameter int W = 8,
   parameter logic [W-1:0] IMPL_MASK = '1,
   parameter logic [W-1:0] RESET_VALUE = '0
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] set_evt,
   input wire logic clr_strobe,
   input wire logic [W-1:0] clr_data,
   output logic [W-1:0] flags
);

   typedef struct packed {
      logic [W-1:0] flags;
   } flag_state_t;

   flag_state_t state_q;
   flag_state_t state_d;

   always_comb
   begin
      state_d = state_q;
      if (clr_strobe)
      begin
         state_d.flags = state_q.flags & ~clr_data;
      end
      // Set wins over a clear in the same cycle
      state_d.flags = (state_d.flags | set_evt) & IMPL_MASK;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_q.flags <= RESET_VALUE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign flags = state_q.flags;

endmodule

`default_nettype wire

// >>> irq_enable_bank.sv
// Read/write enable bank with unimplemented bits held at zero.
// Assumes the write strobe is one cycle long and on the same clock.

`timescale 1ns/10ps
`default_nettype none

module irq_enable_bank
   import peripheral_irq_pkg::*;
#(
   parameter int W = 8,
   parameter logic [W-1:0] IMPL_MASK = '1,
   parameter logic [W-1:0] RESET_VALUE = '0
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_strobe,
   input wire logic [W-1:0] wr_data,
   output logic [W-1:0] value
);

   typedef struct packed {
      logic [W-1:0] value;
   } enable_state_t;

   enable_state_t state_q;
   enable_state_t state_d;

   always_comb
   begin
      state_d = state_q;
      if (wr_strobe)
      begin
         state_d.value = wr_data & IMPL_MASK;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_q.value <= RESET_VALUE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign value = state_q.value;

endmodule

`default_nettype wire

// >>> peripheral_irq_enable_bank2.sv
// Top of the peripheral interrupt enable block: enable banks, pending flags,
// global enables, register port and the request toward the processor.
// Assumes peripheral events are one-cycle pulses or levels on clk_sys.

`timescale 1ns/10ps
`default_nettype none

module peripheral_irq_enable_bank2
   import peripheral_irq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire reg_req_t reg_req,
   input wire periph_evt_t periph_evt,
   output logic [DATA_W-1:0] rd_data,
   output logic periph_irq,
   output logic periph_pending
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] control;
      logic [DATA_W-1:0] rd_data;
      logic irq;
      logic pending;
   } top_state_t;

   top_state_t state_q;
   top_state_t state_d;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
      addr_hit = (addr == target);
   endfunction

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   typedef struct packed {
      logic enable_one;
      logic enable_two;
      logic flag_one;
      logic flag_two;
      logic control;
   } wr_sel_t;

   wr_sel_t wr_sel;

   // Read-only and unmapped indices select nothing
   always_comb
   begin
      wr_sel = '0;
      if (!reg_req.wr)
      begin
         wr_sel = '0;
      end
      else if (addr_hit(reg_req.addr, ADDR_ENABLE_ONE))
      begin
         wr_sel.enable_one = 1'b1;
      end
      else if (addr_hit(reg_req.addr, ADDR_ENABLE_TWO))
      begin
         wr_sel.enable_two = 1'b1;
      end
      else if (addr_hit(reg_req.addr, ADDR_FLAG_ONE))
      begin
         wr_sel.flag_one = 1'b1;
      end
      else if (addr_hit(reg_req.addr, ADDR_FLAG_TWO))
      begin
         wr_sel.flag_two = 1'b1;
      end
      else if (addr_hit(reg_req.addr, ADDR_CONTROL))
      begin
         wr_sel.control = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Event packing into bank layouts
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] evt_two;
   logic [DATA_W-1:0] evt_one;

   always_comb
   begin
      evt_two = '0;
      evt_two[BIT_OSC_FAIL] = periph_evt.osc_fail;
      evt_two[BIT_COMPARATOR_B] = periph_evt.comparator_b;
      evt_two[BIT_COMPARATOR_A] = periph_evt.comparator_a;
      evt_two[BIT_NVM_WRITE_DONE] = periph_evt.nvm_write_done;
      evt_two[BIT_SERIAL_BUS_COLLISION] = periph_evt.serial_bus_collision;
      evt_two[BIT_CAPTURE_UNIT_B] = periph_evt.capture_unit_b;
   end

   always_comb
   begin
      evt_one = '0;
      evt_one[BIT_TIMER_ONE_OVERFLOW] = periph_evt.timer_one_overflow;
      evt_one[BIT_TIMER_TWO_MATCH] = periph_evt.timer_two_match;
   end

   // ----------------------------------------------------------------
   // Enable banks
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] enable_two;
   logic [DATA_W-1:0] enable_one;
   logic wr_enable_two;
   logic wr_enable_one;

   assign wr_enable_two = wr_sel.enable_two;
   assign wr_enable_one = wr_sel.enable_one;

   irq_enable_bank #(
      .W(DATA_W),
      .IMPL_MASK(MASK_BANK_TWO),
      .RESET_VALUE(RESET_ENABLE)
   ) u_enable_two (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_strobe(wr_enable_two),
      .wr_data(reg_req.wdata),
      .value(enable_two)
   );

   irq_enable_bank #(
      .W(DATA_W),
      .IMPL_MASK(MASK_BANK_ONE),
      .RESET_VALUE(RESET_ENABLE)
   ) u_enable_one (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_strobe(wr_enable_one),
      .wr_data(reg_req.wdata),
      .value(enable_one)
   );

   // ----------------------------------------------------------------
   // Pending flags
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] flag_two;
   logic [DATA_W-1:0] flag_one;
   logic clr_flag_two;
   logic clr_flag_one;

   assign clr_flag_two = wr_sel.flag_two;
   assign clr_flag_one = wr_sel.flag_one;

   irq_flag_bank #(
      .W(DATA_W),
      .IMPL_MASK(MASK_BANK_TWO),
      .RESET_VALUE(RESET_FLAG)
   ) u_flag_two (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .set_evt(evt_two),
      .clr_strobe(clr_flag_two),
      .clr_data(reg_req.wdata),
      .flags(flag_two)
   );

   irq_flag_bank #(
      .W(DATA_W),
      .IMPL_MASK(MASK_BANK_ONE),
      .RESET_VALUE(RESET_FLAG)
   ) u_flag_one (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .set_evt(evt_one),
      .clr_strobe(clr_flag_one),
      .clr_data(reg_req.wdata),
      .flags(flag_one)
   );

   // ----------------------------------------------------------------
   // Request combination
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] active_two;
   logic [DATA_W-1:0] active_one;
   logic any_active;
   logic periph_global_en;
   logic global_en;

   logic any_two;
   logic any_one;

   // Enables gate only the request; the flags still record every event
   for (genvar g = 0; g < DATA_W; g++)
   begin : g_gate
      assign active_two[g] = flag_two[g] & enable_two[g];
      assign active_one[g] = flag_one[g] & enable_one[g];
   end

   assign any_two = |active_two;
   assign any_one = |active_one;
   assign any_active = any_two | any_one;
   assign periph_global_en = state_q.control[BIT_PERIPH_GLOBAL_EN];
   assign global_en = state_q.control[BIT_GLOBAL_EN];

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;

   always_comb
   begin
      rd_mux = READ_UNMAPPED;
      if (addr_hit(reg_req.addr, ADDR_ENABLE_ONE))
      begin
         rd_mux = enable_one;
      end
      else if (addr_hit(reg_req.addr, ADDR_ENABLE_TWO))
      begin
         rd_mux = enable_two & MASK_BANK_TWO;
      end
      else if (addr_hit(reg_req.addr, ADDR_FLAG_ONE))
      begin
         rd_mux = flag_one;
      end
      else if (addr_hit(reg_req.addr, ADDR_FLAG_TWO))
      begin
         rd_mux = flag_two;
      end
      else if (addr_hit(reg_req.addr, ADDR_CONTROL))
      begin
         rd_mux = state_q.control;
      end
      else if (addr_hit(reg_req.addr, ADDR_ACTIVE_ONE))
      begin
         rd_mux = active_one;
      end
      else if (addr_hit(reg_req.addr, ADDR_ACTIVE_TWO))
      begin
         rd_mux = active_two;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      if (wr_sel.control)
      begin
         state_d.control = reg_req.wdata & MASK_CONTROL;
      end
      // Read data stands for one cycle only
      if (reg_req.rd)
      begin
         state_d.rd_data = rd_mux;
      end
      else
      begin
         state_d.rd_data = READ_UNMAPPED;
      end
      // Any enabled flag, before the global enables
      state_d.pending = any_active;
      state_d.irq = any_active && periph_global_en && global_en;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_q.control <= RESET_CONTROL;
         state_q.rd_data <= READ_UNMAPPED;
         state_q.irq <= 1'b0;
         state_q.pending <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_data = state_q.rd_data;
   assign periph_irq = state_q.irq;
   assign periph_pending = state_q.pending;

endmodule

`default_nettype wire

// >>> irq_event_source.sv
// Model of the peripheral event sources feeding the interrupt block.
// Assumes the bench calls pulse() and that events share clk_sys.

`timescale 1ns/10ps
`default_nettype none

module irq_event_source
   import peripheral_irq_pkg::*;
(
   input wire logic clk_sys,
   output var periph_evt_t evt
);
   initial evt = '0;

   // ----------------------------------------
   // One-cycle event pulse
   // ----------------------------------------
   task automatic pulse(input logic [7:0] mask);
      @(posedge clk_sys);
      evt <= periph_evt_t'(mask);
      @(posedge clk_sys);
      evt <= '0;
   endtask
endmodule

`default_nettype wire

// >>> irq_bank_checker.sv
// Port checker for the peripheral interrupt enable block.
// Assumes one clock and a synchronous active-low reset; bound below.

`timescale 1ns/10ps
`default_nettype none

module irq_bank_checker
   import peripheral_irq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire reg_req_t reg_req,
   input wire periph_evt_t periph_evt,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic periph_irq,
   input wire logic periph_pending
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_reset_clears_all: assert property (!$past(rst_n) |-> rd_data == 8'h00
      && !periph_irq && !periph_pending) else $error("outputs not clear after reset");
   a_idle_read_zero: assert property (!$past(reg_req.rd) |-> rd_data == 8'h00)
      else $error("read data not zero outside read");
   a_irq_needs_pending: assert property (periph_irq |-> periph_pending)
      else $error("request without enabled flag");
   a_bank_two_holes: assert property ($past(reg_req.rd)
      && $past(reg_req.addr) == ADDR_ENABLE_TWO |-> rd_data[2:1] == 2'h0)
      else $error("unused enable bits read nonzero");
   a_bank_one_holes: assert property ($past(reg_req.rd)
      && $past(reg_req.addr) == ADDR_ENABLE_ONE |-> rd_data[7:2] == 6'h00)
      else $error("unused bank one bits read nonzero");
   a_unmapped_read_zero: assert property ($past(reg_req.rd)
      && $past(reg_req.addr) > ADDR_ACTIVE_TWO |-> rd_data == 8'h00)
      else $error("unmapped read nonzero");
   a_event_sets_flag: assert property (periph_evt.osc_fail ##1 !reg_req.wr
      ##1 (reg_req.rd && reg_req.addr == ADDR_FLAG_TWO) |=> rd_data[BIT_OSC_FAIL])
      else $error("event did not set its flag");
   a_ctrl_off_quiet: assert property (reg_req.wr && reg_req.addr == ADDR_CONTROL
      && !reg_req.wdata[BIT_PERIPH_GLOBAL_EN] |=> ##1 !periph_irq)
      else $error("request without peripheral global enable");

   c_irq_rise: cover property ($rose(periph_irq));
   c_read_two: cover property (reg_req.rd && reg_req.addr == ADDR_ENABLE_TWO);
   c_osc_event: cover property (periph_evt.osc_fail);
endmodule

bind peripheral_irq_enable_bank2 irq_bank_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_req(reg_req), .periph_evt(periph_evt), .rd_data(rd_data),
   .periph_irq(periph_irq), .periph_pending(periph_pending));

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the peripheral interrupt enable block.
// Assumes the event source model and the bound checker.

`timescale 1ns/10ps
`default_nettype none

module tb
   import peripheral_irq_pkg::*;
;
   logic clk_sys;
   logic rst_n;
   reg_req_t reg_req;
   periph_evt_t evt;
   logic [DATA_W-1:0] rd_data;
   logic periph_irq;
   logic periph_pending;
   int errors;
   int checks;

   peripheral_irq_enable_bank2 i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
      .periph_evt(evt), .rd_data(rd_data), .periph_irq(periph_irq),
      .periph_pending(periph_pending));
   irq_event_source i_src (.clk_sys(clk_sys), .evt(evt));

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_irq(input logic [1:0] exp);
      chk({6'h00, periph_pending, periph_irq}, {6'h00, exp});
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1;
      chk(rd_data, exp);
   endtask

   task automatic settle_chk(input logic [1:0] exp);
      @(posedge clk_sys);
      #1;
      chk_irq(exp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      for (int a = 0; a < 16; a++)
         rd_chk(a[ADDR_W-1:0], 8'h00);
   endtask

   task automatic t_access();
      wr_reg(ADDR_ENABLE_TWO, 8'hFF);
      rd_chk(ADDR_ENABLE_TWO, 8'hF9);
      wr_reg(ADDR_ENABLE_TWO, 8'h06);
      rd_chk(ADDR_ENABLE_TWO, 8'h00);
      wr_reg(ADDR_ENABLE_ONE, 8'hFF);
      rd_chk(ADDR_ENABLE_ONE, 8'h03);
      wr_reg(ADDR_ENABLE_ONE, 8'h00);
      wr_reg(ADDR_ACTIVE_TWO, 8'hFF);
      rd_chk(ADDR_ACTIVE_TWO, 8'h00);
      wr_reg(4'hF, 8'hFF);
      rd_chk(4'hF, 8'h00);
   endtask

   task automatic t_each_event();
      logic [7:0] tab [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h01, 8'h01, 8'h02};
      logic [ADDR_W-1:0] en_a;
      logic [ADDR_W-1:0] fl_a;
      logic [ADDR_W-1:0] ac_a;
      wr_reg(ADDR_CONTROL, 8'h03);
      for (int i = 0; i < 8; i++)
      begin
         en_a = (i < 6) ? ADDR_ENABLE_TWO : ADDR_ENABLE_ONE;
         fl_a = (i < 6) ? ADDR_FLAG_TWO : ADDR_FLAG_ONE;
         ac_a = (i < 6) ? ADDR_ACTIVE_TWO : ADDR_ACTIVE_ONE;
         wr_reg(fl_a, tab[i]);
         wr_reg(en_a, tab[i]);
         rd_chk(en_a, tab[i]);
         i_src.pulse(8'h80 >> i);
         settle_chk(2'h3);
         rd_chk(fl_a, tab[i]);
         rd_chk(ac_a, tab[i]);
         wr_reg(fl_a, tab[i]);
         settle_chk(2'h0);
         wr_reg(en_a, 8'h00);
      end
   endtask

   task automatic t_gating();
      wr_reg(ADDR_CONTROL, 8'h00);
      i_src.pulse(8'h80);
      rd_chk(ADDR_FLAG_TWO, 8'h80);
      chk_irq(2'h0);
      wr_reg(ADDR_ENABLE_TWO, 8'h80);
      settle_chk(2'h2);
      wr_reg(ADDR_CONTROL, 8'h03);
      settle_chk(2'h3);
      rd_chk(ADDR_ACTIVE_TWO, 8'h80);
      wr_reg(ADDR_CONTROL, 8'h02);
      settle_chk(2'h2);
      wr_reg(ADDR_CONTROL, 8'h01);
      settle_chk(2'h2);
      wr_reg(ADDR_FLAG_TWO, 8'h80);
      rd_chk(ADDR_FLAG_TWO, 8'h00);
      // Event and clear of the same bit at one edge: the event wins
      fork
         wr_reg(ADDR_FLAG_TWO, 8'h80);
         i_src.pulse(8'h80);
      join
      rd_chk(ADDR_FLAG_TWO, 8'h80);
   endtask

   task automatic t_mid_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_chk(ADDR_ENABLE_TWO, 8'h00);
      rd_chk(ADDR_FLAG_TWO, 8'h00);
      rd_chk(ADDR_CONTROL, 8'h00);
      chk_irq(2'h0);
   endtask

   task automatic finish_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      errors = 0;
      checks = 0;
      rst_n = 1'b0;
      reg_req = '0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset_values();
      t_access();
      t_each_event();
      t_gating();
      t_mid_reset();
      finish_test();
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      finish_test();
   end
endmodule

`default_nettype wire
